// >>> pkg/sbges_pkg.sv
// sbges_pkg: register indices, reset values, field positions, timing and types
// assumes a 40 MHz pclk; byte address of a register is four times its index
package sbges_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned OFF_DLY_TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * OFF_DLY_TICK_MS;
  localparam int unsigned IDX_MIN_US = 250;
  localparam int unsigned IDX_MIN_CYCLES = (CLK_HZ / 1000000) * IDX_MIN_US;
  localparam logic [32:0] MOTOR_CPR = 33'h0_0002_7100;
  localparam int APB_AW = 16;
  localparam logic [11:0] IDX_ZERO_SPD = 12'h14c;
  localparam logic [11:0] IDX_OFF_DLY = 12'h156;
  localparam logic [11:0] IDX_GEAR_NUM1 = 12'h158;
  localparam logic [11:0] IDX_GEAR_DEN = 12'h15a;
  localparam logic [11:0] IDX_SPD_WIN = 12'h15e;
  localparam logic [11:0] IDX_RSVD_A = 12'h160;
  localparam logic [11:0] IDX_RSVD_B = 12'h162;
  localparam logic [11:0] IDX_RSVD_C = 12'h164;
  localparam logic [11:0] IDX_RSVD_D = 12'h166;
  localparam logic [11:0] IDX_ENC_RES = 12'h180;
  localparam logic [11:0] IDX_GEAR_NUM2 = 12'h182;
  localparam logic [11:0] IDX_GEAR_NUM3 = 12'h184;
  localparam logic [11:0] IDX_GEAR_NUM4 = 12'h186;
  localparam logic [11:0] IDX_CTRL = 12'h188;
  localparam logic [11:0] IDX_SPD_LIM = 12'h18a;
  localparam logic [11:0] IDX_STATUS = 12'h18c;
  localparam logic [31:0] RST_GEAR_NUM = 32'h0000_0010;
  localparam logic [31:0] RST_GEAR_DEN = 32'h0000_000a;
  localparam logic [15:0] RST_SPD_WIN = 16'h000a;
  localparam logic [15:0] RST_ZERO_SPD = 16'h0064;
  localparam logic [15:0] RST_OFF_DLY = 16'h0000;
  localparam logic [31:0] RST_ENC_RES = 32'h0000_09c4;
  localparam logic [31:0] RST_SPD_LIM = 32'h0000_ea60;
  localparam int CTL_PT_BIT = 0;
  localparam int CTL_SCALE_BIT = 1;
  localparam int STS_BRK_BIT = 0;
  localparam int STS_ZSPD_BIT = 1;
  localparam int STS_SPEED_WINDOW_TAG_BIT = 2;
  localparam int STS_ALM_BIT = 3;
  localparam int STS_CODE_LSB = 8;
  localparam logic [7:0] DO_CODE_SPEED_MATCH = 8'h19;

  typedef enum logic [2:0] {
    BRK_ON = 3'b001,
    BRK_DLY = 3'b010,
    BRK_OFF = 3'b100
  } sbges_brk_e;

  function automatic logic [32:0] sbges_abs(input logic signed [32:0] v);
    sbges_abs = v[32] ? $unsigned(-v) : $unsigned(v);
  endfunction

  function automatic logic [31:0] sbges_max(input logic [31:0] a, input logic [31:0] b);
    sbges_max = (a > b) ? a : b;
  endfunction
endpackage

// >>> rtl/sbges_enc_emul.sv
// sbges_enc_emul: encoder emulation pulses and stretched index pulse
// assumes one mot_step per motor feedback count and res_sp not above the count per rev
`timescale 1ns/1ps
module sbges_enc_emul #(
  parameter int unsigned IDX_MIN_CYCLES = sbges_pkg::IDX_MIN_CYCLES,
  parameter logic [32:0] MOT_CPR = sbges_pkg::MOTOR_CPR
) (
  input logic pclk,
  input logic presetn,
  input logic clk_en,
  input logic mot_step,
  input logic [31:0] res_sp,
  output logic enc_pulse_out,
  output logic index_pulse_out
);
  import sbges_pkg::*;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] pos;
    logic [31:0] per;
    logic [31:0] lastper;
    logic [31:0] icnt;
    logic pls;
    logic idx;
  } sbges_enc_s;

  sbges_enc_s q, d;
  logic [32:0] sum;

  always_comb begin
    d = q;
    sum = {1'b0, q.acc} + {1'b0, res_sp};
    if (clk_en) begin
      d.pls = 1'b0;
      if (q.per != 32'hffff_ffff) d.per = q.per + 32'h1;
      if (q.icnt != 32'h0) d.icnt = q.icnt - 32'h1;
      if (mot_step) begin
        // one pulse per res_sp fraction of a rev
        if (sum >= MOT_CPR) begin
          d.acc = 32'(sum - MOT_CPR);
          d.pls = 1'b1;
          d.lastper = q.per;
          d.per = 32'h0;
        end else begin
          d.acc = sum[31:0];
        end
        if ({1'b0, q.pos} == MOT_CPR - 33'h1) begin
          d.pos = 32'h0;
          // width follows the output pulse period, never under the minimum
          d.icnt = sbges_max(q.lastper, 32'(IDX_MIN_CYCLES));
        end else begin
          d.pos = q.pos + 32'h1;
        end
      end
      d.idx = (d.icnt != 32'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign enc_pulse_out = q.pls;
  assign index_pulse_out = q.idx;

  logic [31:0] hcnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 32'h0;
    end else if (clk_en) begin
      hcnt_q <= q.idx ? hcnt_q + 32'h1 : 32'h0;
    end
  end

  AST_IDX_MIN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(index_pulse_out) |-> hcnt_q >= 32'(IDX_MIN_CYCLES))
    else $error("index pulse shorter than minimum");
endmodule

// >>> rtl/sbges_top.sv
// sbges_top: brake release timing, electronic gear, encoder emulation setup
// and speed-match output of a servo drive, parameters on an apb slave
// assumes all inputs synchronous to pclk and motor speed already filtered
//
// Function
// - After servo off, brake release stays on for the off-delay, then drops.
// - During the off-delay, zero speed drops brake release early.
// - When the off-delay expires, brake release drops even at speed.
// - Non-exempt alarm or emergency stop turns a negative off-delay into zero.
// - Zero speed: absolute motor speed below threshold, in 0.1 r/min.
// - Gear numerator defaults to 16 and accepts writes while running.
// - Gear denominator defaults to 10, writes refused when running in pulse mode.
// - Each command pulse scales by one of four numerators over the denominator.
// - Encoder output gives the set pulses per rev, 4 to 40000, default 2500.
// - Scale select reads the count as single-phase or as times-4 count.
// - Index width shrinks as speed and pulse count rise.
// - Index pulse is never narrower than 250 us.
// - A computed index width above the minimum is output as computed.
// - Pulse frequency alarm on encoder fault or speed above its limit.
// - Speed-match output, code 0x19, on when speed error below window.
// - Window of zero holds speed-match output off.
// - Speed error uses the raw user speed command.
// - Speed error uses filtered actual motor speed.
`timescale 1ns/1ps
module sbges_top #(
  parameter int unsigned MS_CYCLES = sbges_pkg::MS_CYCLES,
  parameter int unsigned IDX_MIN_CYCLES = sbges_pkg::IDX_MIN_CYCLES,
  parameter logic [32:0] MOT_CPR = sbges_pkg::MOTOR_CPR
) (
  input logic pclk,
  input logic presetn,
  input logic clk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [sbges_pkg::APB_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic servo_on,
  input logic alarm_stop,
  input logic exempt_alarm,
  input logic emergency_stop,
  input logic signed [31:0] motor_speed,
  input logic signed [31:0] speed_cmd,
  input logic cmd_pulse,
  input logic [1:0] gear_sel,
  input logic mot_step,
  input logic enc_fault,
  output logic brake_release_out,
  output logic speed_match_out,
  output logic pulse_freq_alarm,
  output logic pos_cmd_step,
  output logic enc_pulse_out,
  output logic index_pulse_out
);
  import sbges_pkg::*;

  typedef struct packed {
    sbges_brk_e st;
    logic [15:0] pre;
    logic [15:0] ms;
    logic [15:0] dlat;
    logic brk;
    logic speed_window_tag;
    logic alm;
    logic [47:0] gacc;
    logic step;
    logic [3:0][31:0] num;
    logic [31:0] den;
    logic [15:0] win;
    logic [15:0] dly;
    logic [15:0] zspd;
    logic [31:0] res;
    logic pt;
    logic scl;
    logic [31:0] lim;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } sbges_top_s;

  sbges_top_s q;
  sbges_top_s d;

  logic [32:0] spd_abs;
  logic [32:0] err_abs;
  logic zero_spd;
  logic forced_zero;
  logic [15:0] dly_eff;
  logic den_lock;
  logic acc_first;
  logic acc_done;
  logic [11:0] idx;
  logic mapped;
  logic wr;
  logic [31:0] rd_val;
  logic [31:0] num_sel;
  logic [31:0] res_sp;

  // speed terms, both in 0.1 r/min
  assign spd_abs = sbges_abs({motor_speed[31], motor_speed});
  assign zero_spd = spd_abs < {17'h0, q.zspd};
  // raw command, not the ramped one, against filtered feedback
  assign err_abs = sbges_abs(33'({speed_cmd[31], speed_cmd} - {motor_speed[31], motor_speed}));

  // negative delay: zero on non-exempt alarm or emergency stop, else its magnitude
  assign forced_zero = (alarm_stop && !exempt_alarm) || emergency_stop;
  always_comb begin
    if (!q.dly[15]) begin
      dly_eff = q.dly;
    end else if (forced_zero) begin
      dly_eff = 16'h0;
    end else begin
      dly_eff = 16'(-q.dly);
    end
  end

  assign den_lock = servo_on && q.pt;
  assign acc_first = psel && penable && !q.rdy;
  assign acc_done = psel && penable && q.rdy;
  assign idx = paddr[13:2];
  assign wr = acc_done && pwrite && mapped;
  assign num_sel = q.num[gear_sel];
  assign res_sp = q.scl ? (q.res >> 2) : q.res;

  // read decode; reserved slots read zero and take no write
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:14] == '0);
    rd_val = 32'h0;
    if (idx == IDX_ZERO_SPD) begin
      rd_val = {16'h0, q.zspd};
    end else if (idx == IDX_OFF_DLY) begin
      rd_val = {{16{q.dly[15]}}, q.dly};
    end else if (idx == IDX_GEAR_NUM1) begin
      rd_val = q.num[0];
    end else if (idx == IDX_GEAR_NUM2) begin
      rd_val = q.num[1];
    end else if (idx == IDX_GEAR_NUM3) begin
      rd_val = q.num[2];
    end else if (idx == IDX_GEAR_NUM4) begin
      rd_val = q.num[3];
    end else if (idx == IDX_GEAR_DEN) begin
      rd_val = q.den;
    end else if (idx == IDX_SPD_WIN) begin
      rd_val = {16'h0, q.win};
    end else if (idx == IDX_RSVD_A || idx == IDX_RSVD_B) begin
      rd_val = 32'h0;
    end else if (idx == IDX_RSVD_C || idx == IDX_RSVD_D) begin
      rd_val = 32'h0;
    end else if (idx == IDX_ENC_RES) begin
      rd_val = q.res;
    end else if (idx == IDX_CTRL) begin
      rd_val[CTL_PT_BIT] = q.pt;
      rd_val[CTL_SCALE_BIT] = q.scl;
    end else if (idx == IDX_SPD_LIM) begin
      rd_val = q.lim;
    end else if (idx == IDX_STATUS) begin
      rd_val[STS_BRK_BIT] = q.brk;
      rd_val[STS_ZSPD_BIT] = zero_spd;
      rd_val[STS_SPEED_WINDOW_TAG_BIT] = q.speed_window_tag;
      rd_val[STS_ALM_BIT] = q.alm;
      rd_val[STS_CODE_LSB+:8] = DO_CODE_SPEED_MATCH;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    d = q;
    if (clk_en) begin
      // bus: answer one cycle into the access phase
      d.rdy = acc_first;
      d.err = 1'b0;
      if (acc_first) begin
        d.rdata = (!pwrite && mapped) ? rd_val : 32'h0;
        // a refused denominator write shows as an error answer
        d.err = !mapped || (pwrite && idx == IDX_GEAR_DEN && den_lock);
      end
      if (wr) begin
        if (idx == IDX_ZERO_SPD) begin
          d.zspd = pwdata[15:0];
        end else if (idx == IDX_OFF_DLY) begin
          d.dly = pwdata[15:0];
        end else if (idx == IDX_GEAR_NUM1) begin
          d.num[0] = pwdata;
        end else if (idx == IDX_GEAR_NUM2) begin
          d.num[1] = pwdata;
        end else if (idx == IDX_GEAR_NUM3) begin
          d.num[2] = pwdata;
        end else if (idx == IDX_GEAR_NUM4) begin
          d.num[3] = pwdata;
        end else if (idx == IDX_GEAR_DEN) begin
          if (!den_lock) d.den = pwdata;
        end else if (idx == IDX_SPD_WIN) begin
          d.win = pwdata[15:0];
        end else if (idx == IDX_ENC_RES) begin
          d.res = pwdata;
        end else if (idx == IDX_CTRL) begin
          d.pt = pwdata[CTL_PT_BIT];
          d.scl = pwdata[CTL_SCALE_BIT];
        end else if (idx == IDX_SPD_LIM) begin
          d.lim = pwdata;
        end
      end

      // alarm is sticky; a fresh cause beats a write-one clear
      d.alm = enc_fault || (spd_abs > {1'b0, q.lim}) ||
        (q.alm && !(wr && idx == IDX_STATUS && pwdata[STS_ALM_BIT]));

      // brake release sequence
      case (q.st)
        BRK_OFF: begin
          if (servo_on) d.st = BRK_ON;
        end
        BRK_ON: begin
          if (!servo_on) begin
            // timer starts at the servo-off edge with the delay caught there
            d.pre = 16'h0;
            d.ms = 16'h0;
            d.dlat = dly_eff;
            d.st = (dly_eff == 16'h0) ? BRK_OFF : BRK_DLY;
          end
        end
        BRK_DLY: begin
          if (servo_on) begin
            d.st = BRK_ON;
          end else if (zero_spd) begin
            d.st = BRK_OFF;
          end else if (q.ms >= q.dlat) begin
            d.st = BRK_OFF;
          end else if (32'(q.pre) == MS_CYCLES - 1) begin
            d.pre = 16'h0;
            d.ms = q.ms + 16'h1;
          end else begin
            d.pre = q.pre + 16'h1;
          end
        end
        default: begin
          d.st = BRK_OFF;
        end
      endcase
      d.brk = (d.st == BRK_ON) || (d.st == BRK_DLY);

      // speed match
      d.speed_window_tag = (q.win != 16'h0) && (err_abs < {17'h0, q.win});

      // electronic gear: add the numerator per pulse, emit a step per denominator
      d.step = (q.den != 32'h0) && (q.gacc >= {16'h0, q.den});
      d.gacc = q.gacc + ((cmd_pulse && q.pt) ? {16'h0, num_sel} : 48'h0)
        - (d.step ? {16'h0, q.den} : 48'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= BRK_OFF;
      q.num <= {4{RST_GEAR_NUM}};
      q.den <= RST_GEAR_DEN;
      q.win <= RST_SPD_WIN;
      q.dly <= RST_OFF_DLY;
      q.zspd <= RST_ZERO_SPD;
      q.res <= RST_ENC_RES;
      q.lim <= RST_SPD_LIM;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign brake_release_out = q.brk;
  assign speed_match_out = q.speed_window_tag;
  assign pulse_freq_alarm = q.alm;
  assign pos_cmd_step = q.step;

  sbges_enc_emul #(
    .IDX_MIN_CYCLES(IDX_MIN_CYCLES),
    .MOT_CPR(MOT_CPR)
  ) u_enc (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .mot_step(mot_step),
    .res_sp(res_sp),
    .enc_pulse_out(enc_pulse_out),
    .index_pulse_out(index_pulse_out)
  );

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_BRK_ON: assert property (
    clk_en && servo_on |=> brake_release_out)
    else $error("brake release low while servo on");

  AST_BRK_HOLD: assert property (
    clk_en && q.st == BRK_DLY && !servo_on && !zero_spd && q.ms < q.dlat
    |=> brake_release_out)
    else $error("brake release dropped before delay end");

  AST_BRK_ZSPD: assert property (
    clk_en && q.st == BRK_DLY && !servo_on && zero_spd |=> !brake_release_out)
    else $error("brake release held at zero speed");

  AST_BRK_EXP: assert property (
    clk_en && q.st == BRK_DLY && !servo_on && q.ms >= q.dlat
    |=> !brake_release_out)
    else $error("brake release held after delay");

  AST_NEG_ZERO: assert property (
    clk_en && q.st == BRK_ON && !servo_on && q.dly[15] && forced_zero
    |=> !brake_release_out)
    else $error("negative delay not zero on alarm stop");

  AST_DEN_LOCK: assert property (
    clk_en && acc_done && pwrite && idx == IDX_GEAR_DEN && den_lock
    |=> $stable(q.den) && !pslverr)
    else $error("denominator changed while locked");

  AST_ALM: assert property (
    clk_en && enc_fault |=> pulse_freq_alarm [*1] ##0 q.alm)
    else $error("pulse alarm missed encoder fault");

  AST_SPEED_WINDOW_TAG_ON: assert property (
    clk_en && q.win != 16'h0 && err_abs < {17'h0, q.win} |=> speed_match_out)
    else $error("speed match off inside window");

  AST_SPEED_WINDOW_TAG_ZERO: assert property (
    clk_en && q.win == 16'h0 |=> !speed_match_out)
    else $error("speed match on with zero window");

  COV_EARLY: cover property (
    q.st == BRK_DLY && q.ms != 16'h0 ##1 q.st == BRK_OFF && zero_spd);
  COV_EXPIRE: cover property (
    q.st == BRK_DLY && q.ms >= q.dlat && !zero_spd ##1 !brake_release_out);
  COV_DEN_REFUSED: cover property (
    acc_done && pwrite && idx == IDX_GEAR_DEN && den_lock);
  COV_SPEED_WINDOW_TAG: cover property (!speed_match_out ##1 speed_match_out);
endmodule

// >>> verification/sbges_host_model.sv
// sbges_host_model: host controller side, sends command pulses, counts returned pulses
// assumes every pulse from the drive is one pclk cycle wide
`timescale 1ns/1ps
module sbges_host_model (
  input logic pclk,
  input logic presetn,
  input logic pos_cmd_step,
  input logic enc_pulse_out,
  output logic cmd_pulse
);
  int n_steps = 0;
  int n_enc = 0;
  initial cmd_pulse = 1'b0;
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pos_cmd_step === 1'b1) n_steps++;
    if (presetn === 1'b1 && enc_pulse_out === 1'b1) n_enc++;
  end
  // gap plus one cycle is the idle time between pulses, so the host can be fast or slow
  task automatic send(input int n, input int gap);
    repeat (n) begin
      @(posedge pclk);
      cmd_pulse <= 1'b1;
      @(posedge pclk);
      cmd_pulse <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

// >>> verification/tb_servo_brake_gear_encoder_status.sv
// tb_servo_brake_gear_encoder_status: self-checking bench for sbges_top
// assumes the host model beside it and a short millisecond (MS cycles)
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_servo_brake_gear_encoder_status;
  import sbges_pkg::*;
  localparam int MS = 10;
  typedef struct {logic [11:0] i; logic w; logic [31:0] d; logic [31:0] e; logic er;} sbges_row_s;
  typedef struct {int d; logic al; logic ex; logic em; int early; int lo; int hi;} sbges_brk_s;
  typedef struct {int c; int m; int w; logic e;} sbges_sm_s;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_v;
  logic pready, pslverr, er_v;
  logic servo_on = 0, alarm_stop = 0, exempt_alarm = 0, emergency_stop = 0;
  logic signed [31:0] motor_speed = 0, speed_cmd = 0;
  logic cmd_pulse, mot_step = 0, enc_fault = 0;
  logic [1:0] gear_sel = 0;
  logic brake_release_out, speed_match_out, pulse_freq_alarm, pos_cmd_step, enc_pulse_out;
  logic index_pulse_out, clk_en = 1'b1;
  int n_fail = 0, num_checks = 0, n, n0;
  sbges_row_s rows[] = '{
    '{IDX_GEAR_NUM1, 0, 0, 32'h10, 0}, '{IDX_GEAR_DEN, 0, 0, 32'ha, 0},
    '{IDX_SPD_WIN, 0, 0, 32'ha, 0}, '{IDX_ENC_RES, 0, 0, 32'h9c4, 0},
    '{IDX_STATUS, 0, 0, 32'h1906, 0}, '{IDX_RSVD_B, 1, 32'h5a5a, 0, 0},
    '{IDX_RSVD_B, 0, 0, 0, 0}, '{12'h001, 0, 0, 0, 1}, '{12'h001, 1, 32'h1, 0, 1},
    '{IDX_GEAR_NUM2, 1, 32'h3, 0, 0}, '{IDX_GEAR_NUM3, 1, 32'h5, 0, 0},
    '{IDX_GEAR_NUM4, 1, 32'h7, 0, 0}, '{IDX_GEAR_NUM3, 0, 0, 32'h5, 0},
    '{IDX_CTRL, 1, 32'h1, 0, 0}, '{IDX_ZERO_SPD, 0, 0, 32'h64, 0},
    '{IDX_SPD_LIM, 0, 0, 32'hea60, 0}};
  sbges_brk_s brk[] = '{'{3, 0, 0, 0, 0, 3 * MS, 3 * MS + 6}, '{-3, 1, 0, 0, 0, 1, 4},
    '{-3, 0, 0, 1, 0, 1, 4}, '{-3, 1, 1, 0, 0, 3 * MS, 3 * MS + 6}, '{0, 0, 0, 0, 0, 1, 4},
    '{3, 0, 0, 0, 5, 6, 10}};
  sbges_sm_s sm[] = '{'{500, 491, 10, 1}, '{500, 490, 10, 0}, '{-500, -509, 10, 1},
    '{500, 510, 10, 0}, '{0, 0, 0, 0}};
  int num[4] = '{16, 3, 5, 7};

  always #12.5 pclk = ~pclk;

  sbges_top #(.MS_CYCLES(MS), .IDX_MIN_CYCLES(8), .MOT_CPR(33'd40000)) dut_u (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_on(servo_on), .alarm_stop(alarm_stop), .exempt_alarm(exempt_alarm),
    .emergency_stop(emergency_stop), .motor_speed(motor_speed), .speed_cmd(speed_cmd),
    .cmd_pulse(cmd_pulse), .gear_sel(gear_sel), .mot_step(mot_step), .enc_fault(enc_fault),
    .brake_release_out(brake_release_out), .speed_match_out(speed_match_out),
    .pulse_freq_alarm(pulse_freq_alarm), .pos_cmd_step(pos_cmd_step),
    .enc_pulse_out(enc_pulse_out), .index_pulse_out(index_pulse_out));

  sbges_host_model host (.pclk(pclk), .presetn(presetn), .pos_cmd_step(pos_cmd_step),
    .enc_pulse_out(enc_pulse_out), .cmd_pulse(cmd_pulse));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // request held until pready is seen high at an edge, then released
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) begin
      n_fail++;
      close_out();
    end
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic enc_run(input logic [31:0] ctl, input int e);
    apb(1, IDX_CTRL, ctl);
    n0 = host.n_enc;
    repeat (400) begin
      @(posedge pclk);
      mot_step <= 1'b1;
      @(posedge pclk);
      mot_step <= 1'b0;
    end
    cyc(5);
    `CHK("enc pulses", e, host.n_enc - n0) // pulses per rev scaled
    $display("test enc ctrl %0h done", ctl);
  endtask

  initial begin
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("brake rst", 1'b0, brake_release_out) // off out of reset
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].i, rows[k].d);
      if (!rows[k].w) `CHK("rdata", rows[k].e, rd_v) // reset values
      `CHK("pslverr", rows[k].er, er_v) // refusals by address
    end
    $display("test table done");
    for (int s = 0; s < 4; s++) begin
      gear_sel <= s[1:0];
      n0 = host.n_steps;
      host.send(10, s); // ratios kept inside 1/50..25600
      cyc(10);
      `CHK("gear steps", num[s], host.n_steps - n0) // n over den of 10
    end
    $display("test gear done");
    servo_on <= 1'b1;
    apb(1, IDX_GEAR_DEN, 32'h14);
    `CHK("den err", 1'b1, er_v) // locked while running
    apb(0, IDX_GEAR_DEN, 0);
    `CHK("den val", 32'ha, rd_v) // unchanged
    apb(1, IDX_GEAR_NUM1, 32'h14);
    `CHK("num err", 1'b0, er_v) // open while running
    apb(0, IDX_GEAR_NUM1, 0);
    `CHK("num val", 32'h14, rd_v) // taken
    servo_on <= 1'b0;
    $display("test running writes done");
    foreach (brk[k]) begin
      apb(1, IDX_OFF_DLY, 32'(brk[k].d));
      servo_on <= 1'b1;
      motor_speed <= -1000;
      cyc(4);
      `CHK("brake on", 1'b1, brake_release_out) // held while servo on
      alarm_stop <= brk[k].al;
      exempt_alarm <= brk[k].ex;
      emergency_stop <= brk[k].em;
      servo_on <= 1'b0;
      for (n = 1; n < 300; n++) begin
        @(posedge pclk);
        if (n == brk[k].early) motor_speed <= -50;
        if (brake_release_out === 1'b0) break;
      end
      `CHK("brake delay", 1'b1, n >= brk[k].lo && n <= brk[k].hi)
      alarm_stop <= 1'b0;
      exempt_alarm <= 1'b0;
      emergency_stop <= 1'b0;
      cyc(2);
    end
    $display("test brake done");
    foreach (sm[k]) begin
      apb(1, IDX_SPD_WIN, 32'(sm[k].w));
      speed_cmd <= sm[k].c;
      motor_speed <= sm[k].m;
      cyc(3);
      `CHK("speed match", sm[k].e, speed_match_out) // window
    end
    $display("test speed match done");
    // 400 steps against 40000 counts per rev: a hundredth of a turn each run
    enc_run(32'h0, 25);
    apb(1, IDX_ENC_RES, 32'd40000);
    enc_run(32'h1, 400);
    enc_run(32'h3, 100);
    motor_speed <= 60001;
    cyc(3);
    `CHK("alarm speed", 1'b1, pulse_freq_alarm) // over speed limit
    motor_speed <= 0;
    apb(1, IDX_STATUS, 32'h8);
    cyc(2);
    `CHK("alarm clear", 1'b0, pulse_freq_alarm) // cleared with cause gone
    clk_en <= 1'b0;
    enc_fault <= 1'b1;
    cyc(3);
    `CHK("alarm frozen", 1'b0, pulse_freq_alarm) // enable low holds all state
    clk_en <= 1'b1;
    cyc(3);
    `CHK("alarm fault", 1'b1, pulse_freq_alarm) // encoder fault
    $display("test alarm done");
    // one step per cycle, a pulse every 16 steps, until the count wraps
    apb(1, IDX_ENC_RES, 32'd10000);
    mot_step <= 1'b1;
    for (n = 0; n < 45000 && index_pulse_out !== 1'b1; n++) @(posedge pclk);
    for (n0 = 0; n0 < 100 && index_pulse_out === 1'b1; n0++) @(posedge pclk);
    mot_step <= 1'b0;
    `CHK("index width", 15, n0) // pulse period width, above the minimum
    $display("test index done");
    close_out();
  end
endmodule
